// ---- rtl/adcq_buf.sv ----
// small fifo between converter results and the readout logic
// assumes both sides on the same clock; flush drops held words
module adcq_buf #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    // fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady_q,
    // drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULLC = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LASTP = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_q, rp_q;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    assign push = inValid && inReady_q;
    assign outValid = (cnt_q != '0);
    assign pop = outValid && outReady;
    assign outData = mem[rp_q];

    always_comb begin
        cnt_d = cnt_q;
        if (flush) begin
            cnt_d = '0;
        end else if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            wp_q <= '0;
            rp_q <= '0;
            inReady_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            inReady_q <= (cnt_d != FULLC);
            if (flush) begin
                wp_q <= '0;
                rp_q <= '0;
            end else begin
                if (push) begin
                    wp_q <= (wp_q == LASTP) ? '0 : wp_q + 1'b1;
                end
                if (pop) begin
                    rp_q <= (rp_q == LASTP) ? '0 : rp_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[wp_q] <= inData;
        end
    end
endmodule : adcq_buf

// ---- rtl/adcq_ctrl.sv ----
// conversion sequencing and two-wire readout of a 12-bit sampling converter
// assumes bus pins and straps are asynchronous; converter core runs on mclk
// Summary of operation
// R1: in high-speed mode each result goes straight out, one code per read, with no stack.
// R2: in high-speed mode the clock line is held low after the command byte until a result exists.
// R3: a master staying in high-speed mode ends each read with a repeated start, not a stop.
// R4: any stop aborts a running conversion and returns the block to fast/standard mode.
// R5: the master reads exactly one code per read transfer in high-speed mode.
// R6: a matching read address stops conversion.
// R7: a second consecutive valid command byte is refused and ends the conversion.
// R8: after write addressing, command bit 5 with three zero top bits starts conversion and is acknowledged.
// R9: a command byte with any top bit set is refused, powers down and empties the stack.
// R10: a result goes out as four zeros plus the top four bits, then the low eight bits, msb first.
// R11: in fast/standard mode results stack four deep, newest first, with the converter off during readout.
// R12: high-speed mode is entered by the bus master code sent before addressing.
module adcq_ctrl
    import adcq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // bus pins, open drain
    input wire logic sclIn,
    output logic sclOut_q,
    output logic sclOe_q,
    input wire logic sdaIn,
    output logic sdaOut_q,
    output logic sdaOe_q,
    // device select straps
    input wire logic [1:0] addrSelIn,
    // converter core
    output logic convRun_q,
    input wire logic resValid,
    input wire logic [RES_W-1:0] resData,
    output logic resReady,
    // status
    output logic hsMode_q
);
    adcq_state_t state_q, nextSt_q;
    logic [2:0] sclSync_q, sdaSync_q;
    logic [1:0] strapA_q, strapB_q, devSel_q;
    logic [1:0] strapWait_q;
    logic [2:0] bitCnt_q, depth_q;
    logic [7:0] shReg_q, txSh_q;
    logic ackDrive_q, ackPhase_q, byteSel_q, cmdSeen_q, hsHave_q;
    logic [RES_W-1:0] curWord_q, hsWord_q;
    logic [RES_W-1:0] stack_q [STACK_DEPTH];

    // bus pins and straps pass two flip-flops first
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclSync_q <= 3'h7;
            sdaSync_q <= 3'h7;
            strapA_q <= 2'h0;
            strapB_q <= 2'h0;
        end else begin
            sclSync_q <= {sclSync_q[1:0], sclIn};
            sdaSync_q <= {sdaSync_q[1:0], sdaIn};
            strapA_q <= addrSelIn;
            strapB_q <= strapA_q;
        end
    end

    // straps loaded on each of the first three edges after reset; the third, when the synchroniser holds the pin level, is kept
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strapWait_q <= 2'h0;
            devSel_q <= 2'h0;
        end else if (strapWait_q != 2'h3) begin
            strapWait_q <= strapWait_q + 2'h1;
            devSel_q <= strapB_q;
        end
    end

    logic sclS, sclP, sdaS, sdaP, sclRise, sclFall, startDet, stopDet;
    assign sclS = sclSync_q[1];
    assign sclP = sclSync_q[2];
    assign sdaS = sdaSync_q[1];
    assign sdaP = sdaSync_q[2];
    assign sclRise = sclS && !sclP;
    assign sclFall = !sclS && sclP;
    assign startDet = sclS && sclP && sdaP && !sdaS;
    assign stopDet = sclS && sclP && !sdaP && sdaS;

    // byte decode
    logic [7:0] shNext, nextByte;
    logic byteDone, addrHit, hsCode, rdAddr, trigStart, cmdDone, badCmd, dupCmd;
    logic ackToTx, loadByte, popWord, push, hsTake, bufValid, bufReady;
    logic [RES_W-1:0] bufData, srcWord;
    assign shNext = {shReg_q[6:0], sdaS};
    assign byteDone = (state_q == ST_ADDR || state_q == ST_CMD) && sclRise && bitCnt_q == LAST_BIT;
    assign addrHit = state_q == ST_ADDR && byteDone && shNext[7:1] == {DEV_ID, devSel_q};
    assign hsCode = state_q == ST_ADDR && byteDone && shNext[7:3] == HS_MASTER_CODE;
    assign rdAddr = addrHit && shNext[0];
    assign trigStart = state_q == ST_CMD && sclRise && bitCnt_q == CMD_TRIGGER_BIT
                       && shNext[2:0] == CMD_TOP_ZERO && !cmdSeen_q;
    assign cmdDone = state_q == ST_CMD && byteDone;
    assign badCmd = cmdDone && shNext[7:5] != CMD_TOP_ZERO;
    assign dupCmd = cmdDone && !badCmd && cmdSeen_q;
    assign ackToTx = state_q == ST_ACK && sclFall && ackPhase_q && nextSt_q == ST_TX;
    assign loadByte = ackToTx || (state_q == ST_MACK && sclRise && !sdaS);
    assign popWord = loadByte && byteSel_q;
    assign srcWord = hsMode_q ? hsWord_q : stack_q[0];
    assign nextByte = byteSel_q ? curWord_q[7:0] : {BYTE0_PAD, srcWord[11:8]}; // [R10]

    // conversion run and bus mode
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            convRun_q <= 1'b0;
            hsMode_q <= 1'b0;
            cmdSeen_q <= 1'b0;
        end else if (stopDet) begin
            convRun_q <= 1'b0; // [R4]
            hsMode_q <= 1'b0; // [R4]
            cmdSeen_q <= 1'b0;
        end else begin
            if (startDet) begin
                cmdSeen_q <= 1'b0;
            end
            if (hsCode) begin
                hsMode_q <= 1'b1; // [R12]
            end
            if (trigStart) begin
                convRun_q <= 1'b1; // [R8]
            end
            if (rdAddr || badCmd || dupCmd) begin
                convRun_q <= 1'b0; // [R6] [R7] [R9]
            end
            if (cmdDone && !badCmd) begin
                cmdSeen_q <= 1'b1;
            end
        end
    end

    // serial bus state machine
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            nextSt_q <= ST_IDLE;
            bitCnt_q <= 3'h0;
            shReg_q <= 8'h00;
            txSh_q <= 8'h00;
            ackDrive_q <= 1'b0;
            ackPhase_q <= 1'b0;
            byteSel_q <= 1'b0;
            curWord_q <= '0;
            sdaOe_q <= 1'b0;
            sclOe_q <= 1'b0;
        end else if (stopDet) begin
            state_q <= ST_IDLE;
            sdaOe_q <= 1'b0;
            sclOe_q <= 1'b0;
        end else if (startDet) begin
            state_q <= ST_ADDR;
            bitCnt_q <= 3'h0;
            sdaOe_q <= 1'b0;
        end else begin
            if (loadByte) begin
                byteSel_q <= !byteSel_q;
                if (!byteSel_q) begin
                    curWord_q <= srcWord;
                end
            end
            case (state_q)
                ST_ADDR, ST_CMD: begin
                    if (sclRise) begin
                        shReg_q <= shNext;
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == LAST_BIT) begin
                            ackPhase_q <= 1'b0;
                            if (state_q == ST_ADDR) begin
                                state_q <= addrHit ? ST_ACK : ST_IDLE;
                                ackDrive_q <= 1'b1;
                                byteSel_q <= 1'b0;
                                nextSt_q <= shNext[0] ? ST_TX : ST_CMD;
                            end else begin
                                state_q <= ST_ACK;
                                ackDrive_q <= !badCmd && !cmdSeen_q; // [R7] [R8] [R9]
                                if (badCmd || cmdSeen_q) begin
                                    nextSt_q <= ST_IDLE;
                                end else begin
                                    nextSt_q <= hsMode_q ? ST_HSWAIT : ST_CMD;
                                end
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        if (!ackPhase_q) begin
                            sdaOe_q <= ackDrive_q;
                            ackPhase_q <= 1'b1;
                        end else begin
                            state_q <= nextSt_q;
                            bitCnt_q <= 3'h0;
                            if (ackToTx) begin
                                sdaOe_q <= !nextByte[7];
                                txSh_q <= {nextByte[6:0], 1'b0};
                            end else begin
                                sdaOe_q <= 1'b0;
                            end
                            if (nextSt_q == ST_HSWAIT) begin
                                sclOe_q <= 1'b1; // [R2]
                            end
                        end
                    end
                end
                ST_HSWAIT: begin
                    if (hsHave_q) begin
                        sclOe_q <= 1'b0; // [R2]
                        state_q <= ST_CMD;
                        bitCnt_q <= 3'h0;
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        sdaOe_q <= !txSh_q[7]; // [R10]
                        txSh_q <= {txSh_q[6:0], 1'b0};
                    end
                    if (sclRise) begin
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == LAST_BIT) begin
                            state_q <= ST_MACK;
                        end
                    end
                end
                ST_MACK: begin
                    if (sclFall) begin
                        sdaOe_q <= 1'b0;
                    end
                    if (sclRise) begin
                        bitCnt_q <= 3'h0;
                        state_q <= sdaS ? ST_IDLE : ST_TX;
                        if (loadByte) begin
                            txSh_q <= nextByte;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // open-drain levels are always low
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclOut_q <= 1'b0;
            sdaOut_q <= 1'b0;
        end else begin
            sclOut_q <= 1'b0;
            sdaOut_q <= 1'b0;
        end
    end

    // result buffer; drain stalls while a high-speed code waits
    assign bufReady = convRun_q && !(hsMode_q && hsHave_q);
    assign push = bufValid && bufReady && !hsMode_q;
    assign hsTake = bufValid && bufReady && hsMode_q;

    adcq_buf #(
        .WIDTH(RES_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(mclk),
        .rstn(rstn),
        .flush(trigStart || stopDet || badCmd),
        .inValid(resValid),
        .inData(resData),
        .inReady_q(resReady),
        .outValid(bufValid),
        .outData(bufData),
        .outReady(bufReady)
    );

    // single code holder for high-speed mode
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hsHave_q <= 1'b0;
            hsWord_q <= '0;
        end else if (trigStart || stopDet) begin
            hsHave_q <= 1'b0; // [R2]
        end else if (hsTake) begin
            hsHave_q <= 1'b1; // [R1]
            hsWord_q <= bufData;
        end else if (popWord && hsMode_q) begin
            hsHave_q <= 1'b0;
        end
    end

    // result stack, newest on top
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
        logic [RES_W-1:0] below, above;
        if (i == 0) begin : g_top
            assign below = bufData;
        end else begin : g_mid
            assign below = stack_q[i-1];
        end
        if (i == STACK_DEPTH - 1) begin : g_bot
            assign above = '0;
        end else begin : g_up
            assign above = stack_q[i+1];
        end
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                stack_q[i] <= '0;
            end else if (badCmd || hsCode) begin
                stack_q[i] <= '0; // [R9]
            end else if (push) begin
                stack_q[i] <= below; // [R11]
            end else if (popWord && !hsMode_q) begin
                stack_q[i] <= above; // [R11]
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            depth_q <= 3'h0;
        end else if (badCmd || hsCode) begin
            depth_q <= 3'h0;
        end else if (push && depth_q != DEPTH_FULL) begin
            depth_q <= depth_q + 3'h1;
        end else if (popWord && !hsMode_q && depth_q != 3'h0) begin
            depth_q <= depth_q - 3'h1;
        end
    end

    property p_hsDirect;
        @(posedge mclk) disable iff (!rstn) hsMode_q |-> depth_q == 3'h0 && !push;
    endproperty
    a_hsDirect: assert property (p_hsDirect) else $error("stack used in hs mode"); // [R1]
    property p_stretch;
        @(posedge mclk) disable iff (!rstn) state_q == ST_HSWAIT |-> sclOe_q;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not held during hs wait"); // [R2]
    property p_release;
        @(posedge mclk) disable iff (!rstn)
            (state_q == ST_HSWAIT && hsHave_q && !stopDet && !startDet) |=> !sclOe_q && state_q == ST_CMD;
    endproperty
    a_release: assert property (p_release) else $error("clock not released after result"); // [R2]
    property p_stopAbort;
        @(posedge mclk) disable iff (!rstn) stopDet |=> !convRun_q && !hsMode_q && state_q == ST_IDLE;
    endproperty
    a_stopAbort: assert property (p_stopAbort) else $error("stop did not abort"); // [R4]
    property p_readStop;
        @(posedge mclk) disable iff (!rstn) rdAddr |=> !convRun_q ##1 !convRun_q;
    endproperty
    a_readStop: assert property (p_readStop) else $error("conversion ran after read address"); // [R6]
    property p_dupCmd;
        @(posedge mclk) disable iff (!rstn) dupCmd |=> !convRun_q && !ackDrive_q && nextSt_q == ST_IDLE;
    endproperty
    a_dupCmd: assert property (p_dupCmd) else $error("second command not refused"); // [R7]
    property p_trig;
        @(posedge mclk) disable iff (!rstn) trigStart |=> convRun_q;
    endproperty
    a_trig: assert property (p_trig) else $error("command bit 5 did not start conversion"); // [R8]
    property p_badCmd;
        @(posedge mclk) disable iff (!rstn) badCmd |=> !convRun_q && depth_q == 3'h0 && !ackDrive_q;
    endproperty
    a_badCmd: assert property (p_badCmd) else $error("wrong command not ignored"); // [R9]
    property p_byte0;
        @(posedge mclk) disable iff (!rstn)
            (state_q == ST_MACK && sclRise && !sdaS && !byteSel_q && !stopDet) |=> txSh_q[7:4] == BYTE0_PAD;
    endproperty
    a_byte0: assert property (p_byte0) else $error("first byte top nibble not zero"); // [R10]
    property p_fsOff;
        @(posedge mclk) disable iff (!rstn) state_q == ST_TX |-> !convRun_q;
    endproperty
    a_fsOff: assert property (p_fsOff) else $error("converter on during readout"); // [R11]
    property p_hsEntry;
        @(posedge mclk) disable iff (!rstn) (hsCode && !stopDet) |=> hsMode_q && state_q == ST_IDLE;
    endproperty
    a_hsEntry: assert property (p_hsEntry) else $error("master code did not enter hs mode"); // [R12]
endmodule : adcq_ctrl

// ---- rtl/adcq_pkg.sv ----
// constants and types for the converter two-wire readout control
// assumes a single 50 MHz system clock; the bus clock is sampled, not used as a clock
package adcq_pkg;
    localparam int RES_W = 12;
    localparam int STACK_DEPTH = 4;
    localparam int BUF_DEPTH = 2;
    // preset address prefix; value is arbitrary
    localparam logic [4:0] DEV_ID = 5'h15;
    // high-speed master code 0000_1xxx, top five bits
    localparam logic [4:0] HS_MASTER_CODE = 5'h01;
    localparam logic [2:0] CMD_TOP_ZERO = 3'h0;
    // bit counter value while command bit 5 is received
    localparam logic [2:0] CMD_TRIGGER_BIT = 3'h2;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] DEPTH_FULL = 3'h4;
    localparam logic [3:0] BYTE0_PAD = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD = 3'b010,
        ST_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_MACK = 3'b101,
        ST_HSWAIT = 3'b110
    } adcq_state_t;
endpackage : adcq_pkg

// ---- sim/adcq_ctrl_bench.sv ----
// self-checking bench for the converter readout control
// assumes a pull-up on both wires and a converter model fed from this bench
module adcq_ctrl_bench;
    import adcq_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk, rstn, sclW, sdaW, sclPull, sdaPull, sclOut, sclOe, sdaOut, sdaOe;
    logic convRun, hsMode, resValid, resReady, rxStb, ack;
    logic [11:0] resData;
    logic [1:0] addrSel;
    logic [7:0] rxByte, adW, adR;
    logic [7:0] expQ[$];
    logic [11:0] words[$];
    int n_mismatch = 0;
    int compares = 0;
    int cycles;

    assign sclW = !((sclOe & !sclOut) | sclPull);
    assign sdaW = !((sdaOe & !sdaOut) | sdaPull);

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    adcq_ctrl DUT (
        .mclk(mclk), .rstn(rstn), .sclIn(sclW), .sclOut_q(sclOut), .sclOe_q(sclOe),
        .sdaIn(sdaW), .sdaOut_q(sdaOut), .sdaOe_q(sdaOe), .addrSelIn(addrSel),
        .convRun_q(convRun), .resValid(resValid), .resData(resData), .resReady(resReady),
        .hsMode_q(hsMode)
    );

    adcq_master MST (
        .mclk(mclk), .sclW(sclW), .sdaW(sdaW), .sclPull(sclPull), .sdaPull(sdaPull),
        .rxByte(rxByte), .rxStb(rxStb)
    );

    task automatic finish_test();
        if (expQ.size() != 0) begin
            n_mismatch++;
            $display("MISMATCH %0t expected bytes never read", $time);
        end
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %b", $time, what, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] d, input logic exp, input string what);
        MST.wbyte(d, ack);
        @(negedge mclk);
        chk(ack, exp, what);
    endtask : wr

    // read one word; byte0 carries four zero bits
    task automatic rdw(input logic [11:0] w, input logic last);
        expQ.push_back({4'h0, w[11:8]});
        expQ.push_back(w[7:0]);
        MST.rbyte(1'b1);
        MST.rbyte(!last);
    endtask : rdw

    // converter model: hands over n random results
    task automatic conv(input int n);
        int k;
        logic rdy;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            resData <= 12'($urandom);
            resValid <= 1'b1;
            k = 0;
            do begin
                @(negedge mclk);
                rdy = resReady;
                @(posedge mclk);
                k++;
            end while (rdy !== 1'b1 && k < 100);
            words.push_back(resData);
            resValid <= 1'b0;
            repeat (20) @(posedge mclk);
        end
    endtask : conv

    always @(posedge mclk) begin
        if (rxStb === 1'b1) begin
            compares++;
            if (expQ.size() == 0 || rxByte !== expQ[0]) begin
                n_mismatch++;
                $display("MISMATCH %0t read byte %h", $time, rxByte);
            end
            if (expQ.size() > 0) begin
                void'(expQ.pop_front());
            end
        end
    end

    initial begin
        cycles = 0;
        while (cycles < 40000) begin
            @(posedge mclk);
            cycles++;
        end
        n_mismatch++;
        $display("MISMATCH %0t timeout", $time);
        finish_test();
    end

    initial begin
        void'($urandom(32'hB0A3));
        rstn = 1'b0;
        resValid = 1'b0;
        resData = 12'h000;
        addrSel = 2'($urandom);
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        adW = {DEV_ID, addrSel, 1'b0};
        adR = adW | 8'h01;
        repeat (6) @(posedge mclk);
        // fast/standard: six results, newest four read back
        MST.start();
        wr(adW, 1'b1, "addr");
        wr(8'($urandom_range(31)), 1'b1, "cmd");
        chk(convRun, 1'b1, "run");
        conv(6);
        MST.start();
        wr(adR, 1'b1, "addr rd");
        chk(convRun, 1'b0, "rd stop");
        for (int i = 5; i >= 2; i--) begin
            rdw(words[i], i == 2);
        end
        chk(convRun, 1'b0, "off in readout");
        words.delete();
        // wrong command powers down and empties the stack
        MST.start();
        wr(adW, 1'b1, "addr");
        wr(8'h1F, 1'b1, "cmd");
        conv(2);
        MST.start();
        wr(adW, 1'b1, "addr");
        wr(8'hE0, 1'b0, "bad cmd");
        chk(convRun, 1'b0, "bad cmd off");
        MST.start();
        wr(adR, 1'b1, "addr rd");
        rdw(12'h000, 1'b1);
        words.delete();
        for (int t = 1; t < 8; t++) begin
            MST.start();
            wr(adW, 1'b1, "addr");
            wr({3'(t), 5'($urandom)}, 1'b0, "bad cmd");
        end
        MST.start();
        wr({DEV_ID, ~addrSel, 1'b0}, 1'b0, "foreign addr");
        // second command in one transfer
        MST.start();
        wr(adW, 1'b1, "addr");
        wr(8'h0A, 1'b1, "cmd");
        wr(8'h00, 1'b0, "second cmd");
        chk(convRun, 1'b0, "second cmd off");
        MST.start();
        wr(adW, 1'b1, "addr");
        wr(8'h00, 1'b1, "cmd");
        MST.stop();
        repeat (4) @(negedge mclk);
        chk(convRun, 1'b0, "stop abort");
        // high speed: stretched clock, one word per read
        MST.start();
        wr({HS_MASTER_CODE, 3'($urandom)}, 1'b0, "master code");
        chk(hsMode, 1'b1, "hs entry");
        for (int k = 0; k < 2; k++) begin
            MST.start();
            wr(adW, 1'b1, "addr");
            wr(8'h15, 1'b1, "cmd");
            repeat (20) @(negedge mclk);
            chk(sclOe, 1'b1, "stretch held");
            conv(1);
            @(negedge mclk);
            chk(sclOe, 1'b0, "stretch freed");
            MST.start();
            wr(adR, 1'b1, "addr rd");
            rdw(words[0], 1'b1);
            words.delete();
            chk(hsMode, 1'b1, "hs kept");
        end
        MST.stop();
        repeat (4) @(negedge mclk);
        chk(hsMode, 1'b0, "hs left");
        chk(convRun, 1'b0, "hs stop abort");
        finish_test();
    end
endmodule : adcq_ctrl_bench

// ---- sim/adcq_master.sv ----
// two-wire bus master model facing the converter slave
// assumes the bench resolves the open-drain wires; a pull high drives the wire low
module adcq_master (
    // clock
    input wire logic mclk,
    // resolved wires
    input wire logic sclW,
    input wire logic sdaW,
    // pulls
    output logic sclPull,
    output logic sdaPull,
    // received bytes
    output logic [7:0] rxByte,
    output logic rxStb
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclPull = 1'b0;
        sdaPull = 1'b0;
        rxByte = 8'h00;
        rxStb = 1'b0;
    end

    always @(posedge mclk) begin
        if (rxStb) begin
            rxStb <= 1'b0;
        end
    end

    // a stretching slave may hold the clock low
    task automatic wait_hi();
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (sclW !== 1'b1 && n < 5000);
    endtask : wait_hi

    // one bit: low 5 cycles, high 3 cycles
    task automatic clk_bit(input logic b, output logic r);
        sdaPull <= !b;
        repeat (4) @(posedge mclk);
        sclPull <= 1'b0;
        wait_hi();
        @(posedge mclk);
        @(negedge mclk);
        r = sdaW;
        repeat (2) @(posedge mclk);
        sclPull <= 1'b1;
        @(posedge mclk);
    endtask : clk_bit

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        @(posedge mclk);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = (r === 1'b0);
    endtask : wbyte

    task automatic rbyte(input logic ack);
        logic r;
        logic [7:0] d;
        @(posedge mclk);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, r);
            d[i] = r;
        end
        rxByte <= d;
        rxStb <= 1'b1;
        clk_bit(!ack, r);
    endtask : rbyte

    // start or repeated start; waits for the slave to release scl first
    task automatic start();
        @(posedge mclk);
        sdaPull <= 1'b0;
        repeat (5) @(posedge mclk);
        sclPull <= 1'b0;
        wait_hi();
        repeat (3) @(posedge mclk);
        sdaPull <= 1'b1;
        repeat (3) @(posedge mclk);
        sclPull <= 1'b1;
        @(posedge mclk);
    endtask : start

    task automatic stop();
        @(posedge mclk);
        sdaPull <= 1'b1;
        repeat (5) @(posedge mclk);
        sclPull <= 1'b0;
        wait_hi();
        repeat (3) @(posedge mclk);
        sdaPull <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask : stop
endmodule : adcq_master
